// ==== pkg/cmd_interp_regs.svh ====
// Frame layout, instruction codes and status values for the command interpreter.
`ifndef CMD_INTERP_REGS_SVH
`define CMD_INTERP_REGS_SVH
`define FRAME_BYTES        4'd9
`define INSTR_STORE        8'h0b
`define INSTR_RESTORE      8'h0c
`define INSTR_REFSEARCH    8'h0d
`define INSTR_READ_INPUT   8'h0f
`define STATUS_OK          8'h64
`define STATUS_BAD_CSUM    8'h01
`define STATUS_BAD_INSTR   8'h02
`define STATUS_BAD_TYPE    8'h03
`define STATUS_BAD_VALUE   8'h04
`define BANK_GLOBAL        8'h00
`define BANK_ANALOG        8'h01
`define BANK_USER          8'h02
`define SEARCH_START       8'h00
`define SEARCH_STOP        8'h01
`define SEARCH_STATUS      8'h02
`define PORT_ALL_INPUTS    8'hff
`define PORT_TEMPERATURE   8'h09
`define PORT_VOLTAGE       8'h08
`define PORT_DIG_OUT_BASE  8'h10
`define NUM_INPUTS         3
`define NUM_OUTPUTS        2
`define USER_VARS          256
`endif

// ==== pkg/cmd_interp_pkg.sv ====
// Types shared by the command interpreter.
`default_nettype none
package cmd_interp_pkg;
    typedef enum logic [4:0] {
        ST_INIT  = 5'b00001,
        ST_RECV  = 5'b00010,
        ST_EXEC  = 5'b00100,
        ST_WAIT  = 5'b01000,
        ST_REPLY = 5'b10000
    } state_e;
endpackage
`default_nettype wire

// ==== logic/cmd_interp.sv ====
// Command interpreter for store, restore, reference search and input read commands.
`timescale 1ns/1ns
`default_nettype none
`include "cmd_interp_regs.svh"

module cmd_interp (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  module_addr,
    input  wire logic [7:0]  host_addr,
    input  wire logic        standalone_mode,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready,
    output logic             nvm_req,
    output logic             nvm_write,
    output logic [7:0]       nvm_bank,
    output logic [7:0]       nvm_index,
    output logic [31:0]      nvm_wdata,
    input  wire logic        nvm_ack,
    input  wire logic [31:0] nvm_rdata,
    input  wire logic        uvar_we,
    input  wire logic [7:0]  uvar_index,
    input  wire logic [31:0] uvar_wdata,
    output logic [31:0]      uvar_rdata,
    output logic             refsearch_start,
    output logic             refsearch_stop,
    input  wire logic        refsearch_active,
    input  wire logic [2:0]  general_input,
    input  wire logic [11:0] adc_ch0,
    input  wire logic [11:0] adc_ch1,
    input  wire logic [11:0] adc_ch2,
    input  wire logic [11:0] adc_voltage,
    input  wire logic [7:0]  temperature_c,
    input  wire logic [1:0]  digital_out_state,
    output logic [31:0]      accumulator,
    output logic             busy
);
    cmd_interp_pkg::state_e state_reg;
    logic [7:0]  frame_reg [0:8];
    logic [3:0]  byte_cnt_reg;
    logic [7:0]  csum_reg;
    logic [31:0] uvar_mem [0:`USER_VARS-1];
    logic [8:0]  init_idx_reg;
    logic        init_phase_reg;
    logic [7:0]  status_reg;
    logic [31:0] value_reg;
    logic [7:0]  reply_reg [0:8];
    logic [2:0]  in_s1_reg;
    logic [2:0]  in_s2_reg;
    logic [2:0]  in_s3_reg;
    logic [2:0]  in_stable_reg;
    logic [7:0]  ins;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] rd_value;
    logic [7:0]  rd_status;

    assign ins       = frame_reg[1];
    assign typ       = frame_reg[2];
    assign bank      = frame_reg[3];
    // Bytes are taken only while idle, so a busy block refuses new frames.
    assign rx_ready  = (state_reg == cmd_interp_pkg::ST_RECV);
    assign tx_valid  = (state_reg == cmd_interp_pkg::ST_REPLY);
    assign tx_data   = reply_reg[byte_cnt_reg];
    assign busy      = (state_reg != cmd_interp_pkg::ST_RECV);
    assign uvar_rdata = uvar_mem[uvar_index];

    // Pins pass three flops; a change is taken once the last two agree.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            in_s1_reg     <= 3'h0;
            in_s2_reg     <= 3'h0;
            in_s3_reg     <= 3'h0;
            in_stable_reg <= 3'h0;
        end else begin
            in_s1_reg <= general_input;
            in_s2_reg <= in_s1_reg;
            in_s3_reg <= in_s2_reg;
            for (int i = 0; i < `NUM_INPUTS; i++) begin
                if (in_s2_reg[i] == in_s3_reg[i]) begin
                    in_stable_reg[i] <= in_s3_reg[i];
                end
            end
        end
    end

    // Input read decode; unknown ports answer with a type error, unknown banks with a value error.
    always_comb begin
        rd_value  = 32'h0;
        rd_status = `STATUS_OK;
        if (bank == `BANK_GLOBAL) begin
            if (typ == `PORT_ALL_INPUTS) begin
                rd_value = {29'h0, in_stable_reg};
            end else if (typ < 8'(`NUM_INPUTS)) begin
                rd_value = {31'h0, in_stable_reg[typ[1:0]]};
            end else if (typ >= `PORT_DIG_OUT_BASE &&
                         typ < `PORT_DIG_OUT_BASE + 8'(`NUM_OUTPUTS)) begin
                rd_value = {31'h0, digital_out_state[typ[0]]};
            end else begin
                rd_status = `STATUS_BAD_TYPE;
            end
        end else if (bank == `BANK_ANALOG) begin
            case (typ)
                8'h00: rd_value = {20'h0, adc_ch0};
                8'h01: rd_value = {20'h0, adc_ch1};
                8'h02: rd_value = {20'h0, adc_ch2};
                `PORT_VOLTAGE: rd_value = {20'h0, adc_voltage};
                `PORT_TEMPERATURE: rd_value = {{24{temperature_c[7]}}, temperature_c};
                default: rd_status = `STATUS_BAD_TYPE;
            endcase
        end else begin
            rd_status = `STATUS_BAD_VALUE;
        end
    end

    // Main sequencer: power-up restore, receive, execute, wait for memory, reply.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg       <= cmd_interp_pkg::ST_INIT;
            byte_cnt_reg    <= 4'h0;
            csum_reg        <= 8'h0;
            init_idx_reg    <= 9'h0;
            init_phase_reg  <= 1'b1;
            status_reg      <= 8'h0;
            value_reg       <= 32'h0;
            accumulator     <= 32'h0;
            nvm_req         <= 1'b0;
            nvm_write       <= 1'b0;
            nvm_bank        <= 8'h0;
            nvm_index       <= 8'h0;
            nvm_wdata       <= 32'h0;
            refsearch_start <= 1'b0;
            refsearch_stop  <= 1'b0;
        end else begin
            refsearch_start <= 1'b0;
            refsearch_stop  <= 1'b0;
            case (state_reg)
                cmd_interp_pkg::ST_INIT: begin
                    if (init_idx_reg == 9'(`USER_VARS)) begin
                        init_phase_reg <= 1'b0;
                        state_reg      <= cmd_interp_pkg::ST_RECV;
                    end else begin
                        nvm_req   <= 1'b1;
                        nvm_write <= 1'b0;
                        nvm_bank  <= `BANK_USER;
                        nvm_index <= init_idx_reg[7:0];
                        state_reg <= cmd_interp_pkg::ST_WAIT;
                    end
                end
                cmd_interp_pkg::ST_RECV: begin
                    if (rx_valid) begin
                        frame_reg[byte_cnt_reg] <= rx_data;
                        if (byte_cnt_reg == `FRAME_BYTES - 4'd1) begin
                            byte_cnt_reg <= 4'h0;
                            // A frame for another address is dropped without a reply.
                            if (frame_reg[0] == module_addr) begin
                                state_reg <= cmd_interp_pkg::ST_EXEC;
                            end
                            status_reg <= (csum_reg == rx_data) ? `STATUS_OK
                                                               : `STATUS_BAD_CSUM;
                        end else begin
                            byte_cnt_reg <= byte_cnt_reg + 4'd1;
                        end
                        csum_reg <= (byte_cnt_reg == `FRAME_BYTES - 4'd1) ? 8'h0
                                                                         : csum_reg + rx_data;
                    end
                end
                cmd_interp_pkg::ST_EXEC: begin
                    value_reg <= 32'h0;
                    state_reg <= cmd_interp_pkg::ST_REPLY;
                    // A frame in error skips the command and replies with value zero.
                    if (status_reg == `STATUS_OK) begin
                        case (ins)
                            `INSTR_STORE: begin
                                // Bank 0 commits on its own; this stores the working copy.
                                nvm_req   <= 1'b1;
                                nvm_write <= 1'b1;
                                nvm_bank  <= bank;
                                nvm_index <= typ;
                                nvm_wdata <= uvar_mem[typ];
                                state_reg <= cmd_interp_pkg::ST_WAIT;
                            end
                            `INSTR_RESTORE: begin
                                if (bank == `BANK_USER) begin
                                    nvm_req   <= 1'b1;
                                    nvm_write <= 1'b0;
                                    nvm_bank  <= bank;
                                    nvm_index <= typ;
                                    state_reg <= cmd_interp_pkg::ST_WAIT;
                                end else begin
                                    status_reg <= `STATUS_BAD_VALUE;
                                end
                            end
                            `INSTR_REFSEARCH: begin
                                if (bank != 8'h00) begin
                                    status_reg <= `STATUS_BAD_VALUE;
                                end else if (typ == `SEARCH_START) begin
                                    refsearch_start <= 1'b1;
                                end else if (typ == `SEARCH_STOP) begin
                                    refsearch_stop <= 1'b1;
                                end else if (typ == `SEARCH_STATUS) begin
                                    value_reg <= {31'h0, refsearch_active};
                                end else begin
                                    status_reg <= `STATUS_BAD_TYPE;
                                end
                            end
                            `INSTR_READ_INPUT: begin
                                status_reg <= rd_status;
                                if (rd_status == `STATUS_OK) begin
                                    // The all-inputs vector always loads the accumulator.
                                    if (standalone_mode || typ == `PORT_ALL_INPUTS) begin
                                        accumulator <= rd_value;
                                    end
                                    if (!standalone_mode) begin
                                        value_reg <= rd_value;
                                    end
                                end
                            end
                            default: status_reg <= `STATUS_BAD_INSTR;
                        endcase
                    end
                end
                cmd_interp_pkg::ST_WAIT: begin
                    if (nvm_ack) begin
                        nvm_req <= 1'b0;
                        // Power-up loads walk every user variable before commands are taken.
                        if (init_phase_reg) begin
                            init_idx_reg <= init_idx_reg + 9'd1;
                            state_reg    <= cmd_interp_pkg::ST_INIT;
                        end else begin
                            state_reg <= cmd_interp_pkg::ST_REPLY;
                        end
                    end
                end
                cmd_interp_pkg::ST_REPLY: begin
                    // Each reply byte stands until the host takes it.
                    if (tx_ready) begin
                        if (byte_cnt_reg == `FRAME_BYTES - 4'd1) begin
                            byte_cnt_reg <= 4'h0;
                            state_reg    <= cmd_interp_pkg::ST_RECV;
                        end else begin
                            byte_cnt_reg <= byte_cnt_reg + 4'd1;
                        end
                    end
                end
                default: state_reg <= cmd_interp_pkg::ST_INIT;
            endcase
        end
    end

    // Working copy of user variables; memory reads overwrite it.
    always_ff @(posedge core_clk) begin
        if (state_reg == cmd_interp_pkg::ST_WAIT && nvm_ack && !nvm_write) begin
            uvar_mem[nvm_index] <= nvm_rdata;
        end else if (uvar_we) begin
            uvar_mem[uvar_index] <= uvar_wdata;
        end
    end

    // Reply frame assembly with running checksum.
    always_comb begin
        reply_reg[0] = host_addr;
        reply_reg[1] = module_addr;
        reply_reg[2] = status_reg;
        reply_reg[3] = ins;
        reply_reg[4] = value_reg[31:24];
        reply_reg[5] = value_reg[23:16];
        reply_reg[6] = value_reg[15:8];
        reply_reg[7] = value_reg[7:0];
        reply_reg[8] = 8'h0;
        for (int k = 0; k < 8; k++) begin
            reply_reg[8] = reply_reg[8] + reply_reg[k];
        end
    end
endmodule
`default_nettype wire

// ==== test/cmd_interp_sva.sv ====
// Port assertions for the command interpreter.
`timescale 1ns/1ns
`default_nettype none
module cmd_interp_sva (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        rx_valid,
    input wire logic        rx_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_ready,
    input wire logic        nvm_req,
    input wire logic        nvm_ack,
    input wire logic [7:0]  nvm_index,
    input wire logic [31:0] nvm_wdata,
    input wire logic        refsearch_start,
    input wire logic        refsearch_stop,
    input wire logic        busy
);
    logic [3:0] tx_cnt_reg;
    logic [7:0] sum_reg;
    logic       rx_seen_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_cnt_reg <= 4'h0;
            sum_reg    <= 8'h00;
        end else if (tx_valid && tx_ready) begin
            tx_cnt_reg <= (tx_cnt_reg == 4'h8) ? 4'h0 : tx_cnt_reg + 4'h1;
            sum_reg    <= (tx_cnt_reg == 4'h8) ? 8'h00 : sum_reg + tx_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) rx_seen_reg <= 1'b0;
        else if (rx_valid && rx_ready) rx_seen_reg <= 1'b1;
    end
    sequence checksum_slot;
        tx_valid && tx_cnt_reg == 4'h8;
    endsequence
    sequence last_reply_byte;
        tx_valid && tx_ready && tx_cnt_reg == 4'h8;
    endsequence
    a_reply_checksum: assert property (checksum_slot |-> tx_data == sum_reg)
        else $error("reply checksum is not the byte sum");
    a_frame_length: assert property (last_reply_byte |=> !tx_valid)
        else $error("reply runs past nine bytes");
    a_ready_after_reply: assert property (last_reply_byte |-> ##[1:4] rx_ready)
        else $error("receiver not ready after reply");
    a_tx_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte changed while stalled");
    a_nvm_req_hold: assert property (nvm_req && !nvm_ack |=> nvm_req && $stable(nvm_index)
        && $stable(nvm_wdata))
        else $error("memory request dropped before ack");
    a_reply_after_ack: assert property (rx_seen_reg && nvm_req && nvm_ack |=> tx_valid)
        else $error("no reply the cycle after memory ack");
    a_nvm_quiet_tx: assert property (nvm_req |-> !tx_valid)
        else $error("reply started before memory access ended");
    a_search_single_pulse: assert property (refsearch_start || refsearch_stop
        |=> !refsearch_start && !refsearch_stop)
        else $error("search pulse longer than one cycle");
    a_rx_when_idle: assert property (rx_ready |-> !busy && !tx_valid && !nvm_req)
        else $error("receiver ready while busy");
endmodule
bind cmd_interp cmd_interp_sva cmd_interp_sva_i (.core_clk, .rst_n, .rx_valid, .rx_ready,
    .tx_valid, .tx_data, .tx_ready, .nvm_req, .nvm_ack, .nvm_index, .nvm_wdata,
    .refsearch_start, .refsearch_stop, .busy);
`default_nettype wire

// ==== test/host_model.sv ====
// Host model that sends command frames and collects the replies.
`timescale 1ns/1ns
`default_nettype none
module host_model #(
    parameter logic [7:0] DEV_ADDR  = 8'h01,
    parameter logic [7:0] HOST_ADDR = 8'h02
) (
    input  wire logic       core_clk,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end
    task automatic transact(input logic [7:0] instr, typ, bank, input logic corrupt,
                            output logic [7:0] status, output logic [31:0] rvalue,
                            output logic ok);
        logic [7:0] f [9];
        logic [7:0] r [9];
        logic [7:0] sum;
        f = '{DEV_ADDR, instr, typ, bank, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        sum = 8'h00;
        for (int k = 0; k < 8; k++) sum = sum + f[k];
        f[8] = corrupt ? ~sum : sum;
        for (int k = 0; k < 9; k++) begin
            @(negedge core_clk);
            rx_valid = 1'b1;
            rx_data  = f[k];
            while (rx_ready !== 1'b1) @(negedge core_clk);
            @(posedge core_clk);
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_data  = ~f[8];
        // Odd reply bytes are stalled one cycle to exercise the hold path.
        for (int k = 0; k < 9; k++) begin
            if (k % 2 == 1) begin
                @(negedge core_clk);
                tx_ready = 1'b0;
            end
            @(negedge core_clk);
            tx_ready = 1'b1;
            while (tx_valid !== 1'b1) @(negedge core_clk);
            r[k] = tx_data;
            @(posedge core_clk);
        end
        @(negedge core_clk);
        tx_ready = 1'b0;
        sum = 8'h00;
        for (int k = 0; k < 8; k++) sum = sum + r[k];
        status = r[2];
        rvalue = {r[4], r[5], r[6], r[7]};
        ok = (sum == r[8]) && (r[0] == HOST_ADDR) && (r[1] == DEV_ADDR) && (r[3] == instr);
    endtask
endmodule
`default_nettype wire

// ==== test/param_store_refsearch_input_cmds_tb.sv ====
// Self-checking bench for the command interpreter.
`timescale 1ns/1ns
`default_nettype none
module param_store_refsearch_input_cmds_tb;
    typedef struct packed {logic [7:0] i, t, b, st; logic [31:0] v;} row_s;
    logic core_clk = 0, rst_n = 0, standalone_mode = 0, nvm_ack = 0, uvar_we = 0;
    logic refsearch_active = 0, rx_valid, rx_ready, tx_valid, tx_ready, nvm_req, nvm_write;
    logic refsearch_start, refsearch_stop, busy, ok, cap_write;
    logic [2:0]  general_input = 3'b101;
    logic [1:0]  digital_out_state = 2'b10;
    logic [7:0]  rx_data, tx_data, nvm_bank, nvm_index, cap_bank, cap_index, st;
    logic [7:0]  uvar_index = 8'h07, temperature_c = 8'h19;
    logic [11:0] adc_ch0 = 12'h12e, adc_ch1 = 12'hfff, adc_ch2 = 12'h000, adc_voltage = 12'h0f0;
    logic [31:0] nvm_wdata, uvar_rdata, accumulator, val, acc0, cap_wdata;
    logic [31:0] nvm_rdata = 32'h0, uvar_wdata = 32'h0;
    int num_errors = 0, samples_checked = 0, starts = 0, stops = 0;
    row_s rows [16];
    logic [31:0] nvm_mem [256];
    always #2 core_clk = ~core_clk;
    cmd_interp cmd_interp_i (.core_clk, .rst_n, .module_addr(8'h01), .host_addr(8'h02),
        .standalone_mode, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
        .nvm_req, .nvm_write, .nvm_bank, .nvm_index, .nvm_wdata, .nvm_ack, .nvm_rdata,
        .uvar_we, .uvar_index, .uvar_wdata, .uvar_rdata, .refsearch_start, .refsearch_stop,
        .refsearch_active, .general_input, .adc_ch0, .adc_ch1, .adc_ch2, .adc_voltage,
        .temperature_c, .digital_out_state, .accumulator, .busy);
    host_model host_model_i (.core_clk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
        .tx_ready);
    // Memory acks one cycle after a request and keeps stored words.
    initial for (int n = 0; n < 256; n++) nvm_mem[n] = {8'ha5, 16'h0000, 8'(n)};
    always @(negedge core_clk) begin
        nvm_ack <= 1'b0;
        nvm_rdata <= ~nvm_rdata;
        if (nvm_req === 1'b1 && !nvm_ack) begin
            nvm_ack   <= 1'b1;
            nvm_rdata <= nvm_mem[nvm_index];
            if (nvm_write === 1'b1) nvm_mem[nvm_index] <= nvm_wdata;
            cap_write <= nvm_write;
            cap_bank  <= nvm_bank;
            cap_index <= nvm_index;
            cap_wdata <= nvm_wdata;
        end
    end
    always @(posedge core_clk) begin
        if (refsearch_start === 1'b1) starts++;
        if (refsearch_stop === 1'b1) stops++;
    end
    task automatic check(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [7:0] i, t, b, input logic bad);
        host_model_i.transact(i, t, b, bad, st, val, ok);
        check({31'h0, ok}, 32'h1);
    endtask
    task automatic results;
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #80000;
        num_errors++;
        $display("ERROR %0t watchdog expired", $time);
        results;
    end
    initial begin
        rows = '{'{8'h0f, 8'h00, 8'h00, 8'h64, 32'h1}, '{8'h0f, 8'h01, 8'h00, 8'h64, 32'h0},
            '{8'h0f, 8'h02, 8'h00, 8'h64, 32'h1}, '{8'h0f, 8'h00, 8'h01, 8'h64, 32'h12e},
            '{8'h0f, 8'h01, 8'h01, 8'h64, 32'hfff}, '{8'h0f, 8'h02, 8'h01, 8'h64, 32'h0},
            '{8'h0f, 8'h09, 8'h01, 8'h64, 32'h19}, '{8'h0f, 8'h08, 8'h01, 8'h64, 32'hf0},
            '{8'h0f, 8'h10, 8'h00, 8'h64, 32'h0}, '{8'h0f, 8'h11, 8'h00, 8'h64, 32'h1},
            '{8'h0d, 8'h02, 8'h00, 8'h64, 32'h0}, '{8'h0d, 8'h03, 8'h00, 8'h03, 32'h0},
            '{8'h63, 8'h00, 8'h00, 8'h02, 32'h0}, '{8'h0f, 8'h00, 8'h05, 8'h04, 32'h0},
            '{8'h0c, 8'h2a, 8'h00, 8'h04, 32'h0}, '{8'h0d, 8'h00, 8'h01, 8'h04, 32'h0}};
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        check(accumulator, 32'h0);
        check({31'h0, tx_valid}, 32'h0);
        check({31'h0, busy}, 32'h1);
        for (int k = 0; k < 2000 && rx_ready !== 1'b1; k++) @(negedge core_clk);
        check({31'h0, rx_ready}, 32'h1);
        check({31'h0, busy}, 32'h0);
        check(uvar_rdata, 32'ha5000007);
        foreach (rows[r]) begin
            acc0 = accumulator;
            run(rows[r].i, rows[r].t, rows[r].b, 1'b0);
            check({24'h0, st}, {24'h0, rows[r].st});
            check(val, rows[r].v);
            check(accumulator, acc0);
        end
        run(8'h0d, 8'h00, 8'h00, 1'b0);
        check({24'h0, st}, 32'h64);
        check(starts, 1);
        run(8'h0d, 8'h01, 8'h00, 1'b0);
        check(stops, 1);
        refsearch_active = 1'b1;
        run(8'h0d, 8'h02, 8'h00, 1'b0);
        check({31'h0, val != 32'h0}, 32'h1);
        uvar_index = 8'h2a;
        uvar_wdata = 32'hcafe0001;
        uvar_we = 1'b1;
        @(negedge core_clk);
        uvar_we = 1'b0;
        run(8'h0b, 8'h2a, 8'h02, 1'b0);
        check({24'h0, st}, 32'h64);
        check({7'h0, cap_write, cap_bank, cap_index, 8'h0}, 32'h01022a00);
        check(cap_wdata, 32'hcafe0001);
        uvar_wdata = 32'h1;
        uvar_we = 1'b1;
        @(negedge core_clk);
        uvar_we = 1'b0;
        @(negedge core_clk);
        check(uvar_rdata, 32'h1);
        run(8'h0c, 8'h2a, 8'h02, 1'b0);
        check({24'h0, st}, 32'h64);
        check(uvar_rdata, 32'hcafe0001);
        standalone_mode = 1'b1;
        run(8'h0f, 8'h00, 8'h01, 1'b0);
        check(accumulator, 32'h12e);
        run(8'h0f, 8'h00, 8'h00, 1'b0);
        check(accumulator, 32'h1);
        general_input = 3'b010;
        repeat (8) @(negedge core_clk);
        run(8'h0f, 8'hff, 8'h00, 1'b0);
        check(accumulator, 32'h2);
        standalone_mode = 1'b0;
        run(8'h0f, 8'h00, 8'h00, 1'b1);
        check({24'h0, st}, 32'h1);
        general_input = 3'b110;
        repeat (8) @(negedge core_clk);
        run(8'h0f, 8'hff, 8'h00, 1'b0);
        check(val, 32'h6);
        check(accumulator, 32'h6);
        run(8'h0f, 8'h01, 8'h00, 1'b0);
        check(val, 32'h1);
        check(accumulator, 32'h6);
        // A reset in mid-run clears the accumulator and reloads the stored user variables.
        uvar_we = 1'b1;
        @(negedge core_clk);
        uvar_we = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        check(accumulator, 32'h0);
        check({31'h0, busy}, 32'h1);
        for (int k = 0; k < 2000 && rx_ready !== 1'b1; k++) @(negedge core_clk);
        check({31'h0, rx_ready}, 32'h1);
        check(uvar_rdata, 32'hcafe0001);
        results;
    end
endmodule
`default_nettype wire
